// file: design/dtx_pkg.sv
// Shared constants and types for the tone transceiver host port and steering logic
package dtx_pkg;
    localparam int CLK_KHZ = 50000;
    localparam int CLK_MHZ = 50;
    // Output latch settle time before the delayed steering flag rises
    localparam int SETTLE_NS = 3000;
    localparam int SETTLE_CYC = (SETTLE_NS * CLK_MHZ + 999) / 1000;
    // Burst mode tone and pause lengths
    localparam int BURST_MS = 51;
    localparam int PAUSE_MS = 51;
    localparam int BURST_CYC = BURST_MS * CLK_KHZ;
    localparam int PAUSE_CYC = PAUSE_MS * CLK_KHZ;
    localparam int TIMER_W = 24;
    localparam int NIB_W = 4;
    // Register select values
    localparam logic RS_DATA = 1'b0;
    localparam logic RS_CTRL = 1'b1;
    // Status nibble bit positions
    localparam int ST_IRQ = 0;
    localparam int ST_TX_READY = 1;
    localparam int ST_DELAYED = 2;
    localparam int ST_SPARE = 3;
    localparam logic [3:0] RX_RESET = 4'h0;
    localparam logic [3:0] TX_RESET = 4'h0;

    // Control nibble, written with register select high
    typedef struct packed {
        logic burst_mode;
        logic irq_enable;
        logic call_progress_mode;
        logic tone_enable;
    } dtx_ctrl_s;
    localparam dtx_ctrl_s CTRL_RESET = '{default: 1'b0};

    // Host pins after synchronisation
    typedef struct packed {
        logic cs_n;
        logic rd_n;
        logic wr_n;
        logic register_select;
        logic [3:0] data;
        logic steer_in;
        logic cp_square;
    } dtx_pins_s;
    localparam dtx_pins_s PINS_RESET = '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, default: '0};

    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_TONE = 2'b01,
        TX_PAUSE = 2'b11
    } dtx_tx_e;
endpackage

// file: design/dtx_host_steer.sv
// Host nibble port, receive steering and burst-timed transmit control
`timescale 1ns/1ns
module dtx_host_steer #(
    parameter int BURST_CYCLES = dtx_pkg::BURST_CYC,
    parameter int PAUSE_CYCLES = dtx_pkg::PAUSE_CYC
) (
    input wire logic i_sys_clk,
    input wire logic i_resetn,
    input wire logic i_cs_n,
    input wire logic i_register_select,
    input wire logic i_rd_n,
    input wire logic i_wr_n,
    input wire logic [3:0] i_host_data_nibble,
    output logic [3:0] o_host_data_nibble,
    output logic o_host_data_oe,
    output logic o_interrupt_or_progress_out,
    output logic o_interrupt_or_progress_oe,
    input wire logic i_tone_valid,
    input wire logic [3:0] i_tone_code,
    input wire logic i_steer_in,
    input wire logic i_cp_square,
    output logic o_early_detect_out,
    output logic o_steer_guard_out,
    output logic o_steer_guard_oe,
    output logic o_tone_on,
    output logic [3:0] o_tone_code
);
    import dtx_pkg::*;

    dtx_pins_s pins_raw;
    dtx_pins_s pins_s1_q;
    dtx_pins_s pins_q;
    dtx_pins_s pins_prev_q;
    dtx_ctrl_s ctrl_q;
    dtx_tx_e tx_state_q;
    dtx_tx_e tx_state_d;
    logic [3:0] rx_data_q;
    logic [3:0] tx_data_q;
    logic [3:0] rd_data_q;
    logic est_q;
    logic delayed_q;
    logic irq_q;
    logic settling_q;
    logic [TIMER_W-1:0] settle_cnt_q;
    logic [TIMER_W-1:0] tx_cnt_q;
    logic [TIMER_W-1:0] tx_cnt_d;
    logic tx_busy_q;

    // Two flops on every host and steering pin; the host strobes are not on our clock
    assign pins_raw = '{cs_n: i_cs_n, rd_n: i_rd_n, wr_n: i_wr_n,
                        register_select: i_register_select, data: i_host_data_nibble,
                        steer_in: i_steer_in, cp_square: i_cp_square};

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            pins_s1_q <= PINS_RESET;
            pins_q <= PINS_RESET;
            pins_prev_q <= PINS_RESET;
        end else begin
            pins_s1_q <= pins_raw;
            pins_q <= pins_s1_q;
            pins_prev_q <= pins_q;
        end
    end

    wire selected = !pins_q.cs_n;
    // Write commits at the trailing edge of the strobe, when data is surely stable
    wire wr_commit = selected && pins_q.wr_n && !pins_prev_q.wr_n;
    wire rd_active = selected && !pins_q.rd_n;
    // Status read side effects happen once, at the end of the read strobe
    wire rd_end = selected && pins_q.rd_n && !pins_prev_q.rd_n;
    wire wr_data = wr_commit && (pins_q.register_select == RS_DATA);
    wire wr_ctrl = wr_commit && (pins_q.register_select == RS_CTRL);
    wire rd_data = rd_end && (pins_q.register_select == RS_DATA);
    wire rd_stat = rd_end && (pins_q.register_select == RS_CTRL);

    wire [3:0] status_nib = {1'b0, delayed_q, !tx_busy_q, irq_q};
    wire [3:0] rd_sel = (pins_q.register_select == RS_DATA) ? rx_data_q : status_nib;

    // Bus driven only during a selected read; sync delay adds two cycles of hold
    assign o_host_data_oe = rd_active;
    assign o_host_data_nibble = rd_data_q;

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rd_data_q <= 4'h0;
        end else begin
            rd_data_q <= rd_active ? rd_sel : 4'h0;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            ctrl_q <= CTRL_RESET;
            tx_data_q <= TX_RESET;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= dtx_ctrl_s'(pins_q.data);
            end
            if (wr_data) begin
                tx_data_q <= pins_q.data;
            end
        end
    end

    // Detection held off in call-progress mode
    wire signal_cond = i_tone_valid && !ctrl_q.call_progress_mode;
    wire steer_rise = pins_q.steer_in && !pins_prev_q.steer_in;
    wire settle_done = settling_q && (settle_cnt_q == TIMER_W'(SETTLE_CYC - 1));

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            est_q <= 1'b0;
        end else begin
            est_q <= signal_cond;
        end
    end
    assign o_early_detect_out = est_q;

    // Guard drives the network toward the agreed level, else lets the RC run
    assign o_steer_guard_out = est_q;
    assign o_steer_guard_oe = (est_q == pins_q.steer_in);

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rx_data_q <= RX_RESET;
            settling_q <= 1'b0;
            settle_cnt_q <= '0;
            delayed_q <= 1'b0;
        end else begin
            if (steer_rise && est_q && !ctrl_q.call_progress_mode) begin
                rx_data_q <= i_tone_code;
                settling_q <= 1'b1;
                settle_cnt_q <= '0;
            end else if (settle_done) begin
                settling_q <= 1'b0;
            end else if (settling_q) begin
                settle_cnt_q <= settle_cnt_q + TIMER_W'(1);
            end
            // Steering low validates the pause and rearms the receiver
            if (settle_done) begin
                delayed_q <= 1'b1;
            end else if (!pins_q.steer_in) begin
                delayed_q <= 1'b0;
            end
        end
    end

    // Burst sequencer: tone, then pause, then done
    wire tx_start = wr_data && ctrl_q.tone_enable && ctrl_q.burst_mode && !tx_busy_q;
    wire tone_end = (tx_cnt_q == TIMER_W'(BURST_CYCLES - 1));
    wire pause_end = (tx_cnt_q == TIMER_W'(PAUSE_CYCLES - 1));
    wire burst_done = (tx_state_q == TX_PAUSE) && pause_end;

    always_comb begin
        tx_state_d = tx_state_q;
        tx_cnt_d = tx_cnt_q + TIMER_W'(1);
        unique case (tx_state_q)
            TX_IDLE: begin
                tx_cnt_d = '0;
                if (tx_start) begin
                    tx_state_d = TX_TONE;
                end
            end
            TX_TONE: begin
                if (tone_end) begin
                    tx_state_d = TX_PAUSE;
                    tx_cnt_d = '0;
                end
            end
            TX_PAUSE: begin
                if (pause_end) begin
                    tx_state_d = TX_IDLE;
                    tx_cnt_d = '0;
                end
            end
            default: begin
                tx_state_d = TX_IDLE;
                tx_cnt_d = '0;
            end
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            tx_state_q <= TX_IDLE;
            tx_cnt_q <= '0;
            tx_busy_q <= 1'b0;
            o_tone_on <= 1'b0;
            o_tone_code <= 4'h0;
        end else begin
            tx_state_q <= tx_state_d;
            tx_cnt_q <= tx_cnt_d;
            tx_busy_q <= (tx_state_d != TX_IDLE);
            // Outside burst mode the tone follows the enable bit directly
            o_tone_on <= ctrl_q.burst_mode ? (tx_state_d == TX_TONE)
                                           : ctrl_q.tone_enable;
            o_tone_code <= tx_data_q;
        end
    end

    // Sticky event flag; a new event beats a clearing status read
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            irq_q <= 1'b0;
        end else if (burst_done || settle_done) begin
            irq_q <= 1'b1;
        end else if (rd_stat || rd_data) begin
            irq_q <= 1'b0;
        end
    end

    // Open drain: the pin only ever sinks, so the enable carries the level
    wire irq_pull = ctrl_q.irq_enable && irq_q;
    wire cp_pull = !pins_q.cp_square;
    assign o_interrupt_or_progress_out = 1'b0;
    assign o_interrupt_or_progress_oe = ctrl_q.call_progress_mode ? cp_pull : irq_pull;
endmodule

// file: sim/dtx_host_steer_properties.sv
// Concurrent checks on the host port and steering outputs
`timescale 1ns/1ns
module dtx_checker (
    input wire logic i_sys_clk,
    input wire logic i_resetn,
    input wire logic i_cs_n,
    input wire logic i_rd_n,
    input wire logic i_tone_valid,
    input wire logic i_steer_in,
    input wire logic [3:0] o_host_data_nibble,
    input wire logic o_host_data_oe,
    input wire logic o_interrupt_or_progress_out,
    input wire logic o_early_detect_out,
    input wire logic o_steer_guard_out,
    input wire logic o_steer_guard_oe
);
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_resetn);
    // Host and steering pins pass two sync flops, so their relations look two edges back; tone valid looks one
    bus_drive_window_a: assert property (
        o_host_data_oe == (!$past(i_cs_n, 2) && !$past(i_rd_n, 2))) else $error("bus enable wrong");
    deselect_quiet_a: assert property ($past(i_cs_n, 2) |-> !o_host_data_oe)
        else $error("bus driven while deselected");
    idle_data_zero_a: assert property (!$past(o_host_data_oe) |-> o_host_data_nibble == 4'h0)
        else $error("data not cleared");
    early_drop_a: assert property (!$past(i_tone_valid) |-> !o_early_detect_out)
        else $error("early detect held");
    early_rise_a: assert property ($rose(o_early_detect_out) |-> $past(i_tone_valid))
        else $error("early detect without pair");
    guard_level_a: assert property (o_steer_guard_out == o_early_detect_out)
        else $error("guard level wrong");
    guard_drive_a: assert property (
        o_steer_guard_oe == (o_early_detect_out == $past(i_steer_in, 2))) else $error("guard enable");
    irq_open_drain_a: assert property (o_interrupt_or_progress_out == 1'b0)
        else $error("irq pin driven high");
endmodule
bind dtx_host_steer dtx_checker u_chk (.*);

// file: sim/dtx_host_model.sv
// Host microcontroller model driving the nibble bus
`timescale 1ns/1ns
module dtx_host_model (
    input wire logic i_sys_clk,
    input wire logic [3:0] i_host_data_nibble,
    input wire logic i_host_data_oe,
    output logic o_cs_n,
    output logic o_register_select,
    output logic o_rd_n,
    output logic o_wr_n,
    output logic [3:0] o_host_data_nibble
);
    logic drv = 1'b0;
    logic [3:0] wd = 4'h0;
    logic [3:0] junk = 4'h5;
    initial begin
        o_cs_n = 1'b1;
        o_register_select = 1'b0;
        o_rd_n = 1'b1;
        o_wr_n = 1'b1;
    end
    // Undriven bus shows the inverse of its last value, never a stale one
    always @(posedge i_sys_clk) junk <= ~o_host_data_nibble;
    assign o_host_data_nibble = drv ? wd : (i_host_data_oe ? i_host_data_nibble : junk);
    task automatic access(input logic rs, input logic wr, input logic [3:0] d, output logic [3:0] q);
        o_cs_n = 1'b0;
        o_register_select = rs;
        drv = wr;
        wd = d;
        o_rd_n = wr;
        o_wr_n = !wr;
        repeat (5) @(posedge i_sys_clk);
        #1;
        // Resolved bus, so a missing output enable shows up as junk
        q = o_host_data_nibble;
        o_rd_n = 1'b1;
        o_wr_n = 1'b1;
        // Select held past the strobe so the synced commit still sees it
        repeat (3) @(posedge i_sys_clk);
        #1;
        o_cs_n = 1'b1;
        drv = 1'b0;
        repeat (3) @(posedge i_sys_clk);
        #1;
    endtask
    // Strobe with chip select left high; the device must ignore it
    task automatic stray(input logic rs, input logic wr, input logic [3:0] d);
        o_register_select = rs;
        drv = wr;
        wd = d;
        o_rd_n = wr;
        o_wr_n = !wr;
        repeat (5) @(posedge i_sys_clk);
        #1;
        o_rd_n = 1'b1;
        o_wr_n = 1'b1;
        repeat (3) @(posedge i_sys_clk);
        #1;
        drv = 1'b0;
        repeat (3) @(posedge i_sys_clk);
        #1;
    endtask
endmodule

// file: sim/tb.sv
// Testbench for the tone transceiver host port and steering logic
`timescale 1ns/1ns
module tb;
    import dtx_pkg::*;
    localparam int BURST = 20;
    logic i_sys_clk = 1'b0;
    logic i_resetn = 1'b0;
    logic i_tone_valid = 1'b0;
    logic i_steer_in = 1'b0;
    logic i_cp_square = 1'b0;
    logic [3:0] i_tone_code = 4'h0;
    logic cs_n, rs, rd_n, wr_n, d_oe, irq_out, irq_oe, early, g_out, g_oe, tone_on;
    logic [3:0] d_to_dut, d_from_dut, tone_code, rd_val;
    logic [3:0] codes [2] = '{4'h9, 4'h3};
    int fails = 0;
    int n_checks = 0;
    int on_cyc = 0;
    always #10 i_sys_clk = ~i_sys_clk;
    always @(posedge i_sys_clk) if (tone_on === 1'b1) on_cyc++;
    dtx_host_steer #(.BURST_CYCLES(BURST), .PAUSE_CYCLES(BURST)) dut (
        .i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_cs_n(cs_n), .i_register_select(rs),
        .i_rd_n(rd_n), .i_wr_n(wr_n), .i_host_data_nibble(d_to_dut),
        .o_host_data_nibble(d_from_dut), .o_host_data_oe(d_oe),
        .o_interrupt_or_progress_out(irq_out), .o_interrupt_or_progress_oe(irq_oe),
        .i_tone_valid(i_tone_valid), .i_tone_code(i_tone_code), .i_steer_in(i_steer_in),
        .i_cp_square(i_cp_square), .o_early_detect_out(early), .o_steer_guard_out(g_out),
        .o_steer_guard_oe(g_oe), .o_tone_on(tone_on), .o_tone_code(tone_code));
    dtx_host_model host (.i_sys_clk(i_sys_clk), .i_host_data_nibble(d_from_dut),
        .i_host_data_oe(d_oe), .o_cs_n(cs_n), .o_register_select(rs), .o_rd_n(rd_n),
        .o_wr_n(wr_n), .o_host_data_nibble(d_to_dut));
    task automatic chk(input logic [3:0] got, input logic [3:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic summarize();
        $display("checks=%0d mismatches=%0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge i_sys_clk);
        #1;
    endtask
    task automatic wait_tone(input logic lvl);
        int n;
        n = 0;
        while (tone_on !== lvl && n < 200) begin
            tick(1);
            n++;
        end
        if (n >= 200) begin
            fails++;
            summarize();
        end
    endtask
    initial begin
        tick(10);
        chk({g_oe, irq_oe, d_oe, early}, 4'h8);
        i_resetn = 1'b1;
        host.access(RS_CTRL, 1'b1, 4'hd, rd_val);
        host.access(RS_DATA, 1'b1, 4'h6, rd_val);
        wait_tone(1'b1);
        chk(tone_code, 4'h6);
        wait_tone(1'b0);
        chk(4'(on_cyc), 4'(BURST));
        chk(4'(on_cyc >> 4), 4'(BURST >> 4));
        tick(BURST - 3);
        chk({3'h0, irq_oe}, 4'h0);
        tick(6);
        chk({3'h0, irq_oe}, 4'h1);
        host.stray(RS_CTRL, 1'b0, 4'h0);
        chk({3'h0, irq_oe}, 4'h1);
        host.stray(RS_DATA, 1'b1, 4'h9);
        chk({3'h0, tone_on}, 4'h0);
        chk(tone_code, 4'h6);
        host.access(RS_CTRL, 1'b0, 4'h0, rd_val);
        chk(rd_val & 4'h3, 4'h3);
        chk({3'h0, irq_oe}, 4'h0);
        // Second pair arrives only after the steering input fell again
        foreach (codes[i]) begin
            i_tone_code = codes[i];
            i_tone_valid = 1'b1;
            tick(2);
            chk({3'h0, early}, 4'h1);
            i_steer_in = 1'b1;
            tick(160);
            chk({3'h0, irq_oe}, 4'h1);
            host.access(RS_DATA, 1'b0, 4'h0, rd_val);
            chk(rd_val, codes[i]);
            host.access(RS_CTRL, 1'b0, 4'h0, rd_val);
            chk(rd_val & 4'h4, 4'h4);
            i_tone_valid = 1'b0;
            tick(2);
            chk({3'h0, early}, 4'h0);
            i_steer_in = 1'b0;
            tick(4);
        end
        host.access(RS_CTRL, 1'b1, 4'h6, rd_val);
        i_tone_valid = 1'b1;
        tick(3);
        chk({3'h0, early}, 4'h0);
        i_cp_square = 1'b1;
        tick(3);
        chk({3'h0, irq_oe}, 4'h0);
        i_cp_square = 1'b0;
        tick(3);
        chk({3'h0, irq_oe}, 4'h1);
        // Leaving call-progress mode rearms detection; steady tone outside burst mode
        host.access(RS_CTRL, 1'b1, 4'h1, rd_val);
        chk({1'b0, irq_oe, tone_on, early}, 4'h3);
        summarize();
    end
endmodule
